/* verification/cfs_chk.sv */
// Checker for the clock fanout block
`timescale 1ns/100ps
`default_nettype none
module cfs_chk(input wire logic clk_i,rst_i,diff_clk_p_i,diff_clk_n_i,aux_clk_i,input_sel_i,
	out_gate_n_i,input wire logic [4:0] fanout_out_o,fanout_out_n_o);
wire c=input_sel_i?aux_clk_i:diff_clk_p_i&~diff_clk_n_i;
default clocking @(posedge clk_i);endclocking
default disable iff(rst_i);
sequence fall_s;!$past(rst_i)&&$fell(c);endsequence
AST_NEG:assert property(fanout_out_n_o==~fanout_out_o)else $error("n");
AST_LOW:assert property(!c|=>fanout_out_o==0)else $error("l");
AST_RUN:assert property(c&&|fanout_out_o|=>&fanout_out_o)else $error("r");
AST_ON:assert property(fall_s##0!out_gate_n_i##1 c|=>&fanout_out_o)else $error("e");
AST_OFF:assert property(fall_s##0 out_gate_n_i|=>##1 fanout_out_o==0)else $error("d");
AST_SAME:assert property(fanout_out_o==0 || &fanout_out_o)else $error("s");
AST_LAT:assert property(|fanout_out_o |-> $past(c))else $error("t");
endmodule // cfs_chk
`default_nettype wire

/* verification/cfs_src.sv */
// Clock source model for the fanout inputs
`timescale 1ns/100ps
`default_nettype none
module cfs_src(input wire logic clk_i,input wire logic op_i,input wire logic [1:0] r_i,
	output logic p_o=1'h0,output logic n_o=1'h1,output logic a_o=1'h0);
// An open pair leaves both halves low
always @(negedge clk_i) begin
	a_o<=r_i[1];
	p_o<=r_i[0]&~op_i;
	n_o<=~r_i[0]&~op_i;
end
endmodule // cfs_src
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the clock fanout block
`timescale 1ns/100ps
`default_nettype none
module testbench;
logic clk_i=0,rst_i=1,sel=0,gn=0,op=0,c,pv=0,g=0,e=0;
logic p,n,a;
logic [1:0] r=0;
logic [4:0] q,qn;
integer seed=83,rv,num_errors=0,total_checks=0;
cfs_src src(.clk_i(clk_i),.op_i(op),.r_i(r),.p_o(p),.n_o(n),.a_o(a));
cfs_clock_fanout uut(.clk_i(clk_i),.rst_i(rst_i),.diff_clk_p_i(p),.diff_clk_n_i(n),
	.aux_clk_i(a),.input_sel_i(sel),.out_gate_n_i(gn),.fanout_out_o(q),.fanout_out_n_o(qn));
initial forever #5 clk_i=~clk_i;
task give_verdict;
	if(num_errors==0&&total_checks>0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
task check_q(input logic x);
	total_checks++;
	if(q!=={5{x}}) begin num_errors++; $display("ERROR %0t noninverting outputs",$time); end
endtask
task check_qn(input logic x);
	total_checks++;
	if(qn!=={5{~x}}) begin num_errors++; $display("ERROR %0t inverting outputs",$time); end
endtask
// Reference model: the gate loads on a falling chosen edge, outputs copy clock and gate
always @(posedge clk_i) begin
	c=sel?a:p&~n;
	if(rst_i) {pv,g,e}=3'h0;
	else begin if(pv&!c) g=!gn; e=c&g; pv=c; end
end
always @(negedge clk_i) #1 if(!rst_i) begin
	check_q(e);
	check_qn(e);
end
initial begin
	repeat(4) @(negedge clk_i);
	gn<=1'h0;
	rst_i<=0;
	repeat(600) begin
		@(negedge clk_i);
		rv=$random(seed);
		r<=rv[1:0];
		if(rv[4:2]==0) gn<=~gn;
		if(rv[9:5]==0) sel<=~sel;
		if(rv[14:10]==0) op<=~op;
	end
	give_verdict;
end
initial begin #10000; num_errors++; give_verdict; end
endmodule // testbench
bind cfs_clock_fanout cfs_chk chk(.clk_i(clk_i),.rst_i(rst_i),.diff_clk_p_i(diff_clk_p_i),
	.diff_clk_n_i(diff_clk_n_i),.aux_clk_i(aux_clk_i),.input_sel_i(input_sel_i),
	.out_gate_n_i(out_gate_n_i),.fanout_out_o(fanout_out_o),.fanout_out_n_o(fanout_out_n_o));
`default_nettype wire

/* verilog/cfs_clock_fanout.v */
// Clock fanout with input selector and falling-edge output gate
`timescale 1ns/100ps
`default_nettype none
`include "cfs_map.vh"

module cfs_clock_fanout (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Clock inputs, sampled on clk_i
	input wire diff_clk_p_i,
	input wire diff_clk_n_i,
	input wire aux_clk_i,
	// Control pins
	input wire input_sel_i,
	input wire out_gate_n_i,
	// Fanout outputs
	output reg [`CFS_FANOUT_N-1:0] fanout_out_o,
	output reg [`CFS_FANOUT_N-1:0] fanout_out_n_o
);

	// Gate states; after reset the gate waits in its own state until the first load with the gate pin low
	localparam GATE_IDLE = 2'h0;
	localparam GATE_OFF = 2'h1;
	localparam GATE_ON = 2'h2;

	// Pair decode: only p high with n low is a high level, so an open pair reads low
	function pair_level;
		input p;
		input n;
		begin
			pair_level = p & ~n;
		end
	endfunction

	// Two-way selector between the pair and the single-ended clock
	function select_clk;
		input sel;
		input pair;
		input aux;
		begin
			case (sel)
				`CFS_SEL_DIFF: begin
					select_clk = pair;
				end
				`CFS_SEL_AUX: begin
					select_clk = aux;
				end
				default: begin
					select_clk = 1'h0;
				end
			endcase
		end
	endfunction

	// Falling edge seen against the previous sample of the chosen clock
	function is_falling;
		input prev;
		input now;
		begin
			is_falling = prev & ~now;
		end
	endfunction

	// Whether a gate state lets the chosen clock through
	function gate_passes;
		input [1:0] state;
		begin
			case (state)
				GATE_IDLE: begin
					gate_passes = 1'h0;
				end
				GATE_OFF: begin
					gate_passes = 1'h0;
				end
				GATE_ON: begin
					gate_passes = 1'h1;
				end
				default: begin
					gate_passes = 1'h0;
				end
			endcase
		end
	endfunction

	// Inverting half of a lane pair
	function lane_inv;
		input level;
		begin
			lane_inv = ~level;
		end
	endfunction

	// Input stage
	wire pair_clk;
	reg chosen_clk;

	// Edge detector
	reg chosen_q;
	reg chosen_d;
	reg gate_load;

	// Gate state machine
	reg gate_req;
	reg [1:0] gate_q;
	reg [1:0] gate_d;

	// Lane drive
	reg lane_pass;
	reg lane_on;
	wire [`CFS_FANOUT_N-1:0] lane_d;
	wire [`CFS_FANOUT_N-1:0] lane_n_d;

	assign pair_clk = pair_level(diff_clk_p_i, diff_clk_n_i);

	always @* begin
		chosen_clk = select_clk(input_sel_i, pair_clk, aux_clk_i);
	end

	always @* begin
		gate_req = ~out_gate_n_i;
	end

	// Previous sample of the chosen clock
	always @* begin
		chosen_d = chosen_clk;
	end

	// Only a falling edge of the chosen clock may load the gate
	always @* begin
		gate_load = is_falling(chosen_q, chosen_clk);
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			chosen_q <= `CFS_CLK_RST;
		end else begin
			chosen_q <= chosen_d;
		end
	end

	always @* begin
		gate_d = gate_q;
		case (gate_q)
			GATE_IDLE: begin
				if (gate_load && gate_req) begin
					gate_d = GATE_ON;
				end else begin
					gate_d = GATE_IDLE;
				end
			end
			GATE_OFF: begin
				if (gate_load && gate_req) begin
					gate_d = GATE_ON;
				end else begin
					gate_d = GATE_OFF;
				end
			end
			GATE_ON: begin
				if (gate_load && !gate_req) begin
					gate_d = GATE_OFF;
				end else begin
					gate_d = GATE_ON;
				end
			end
			default: begin
				gate_d = GATE_OFF;
			end
		endcase
	end

	// Edge-triggered capture of the gate pin; the pin never reaches a lane directly
	always @(posedge clk_i) begin
		if (rst_i) begin
			gate_q <= `CFS_GATE_RST;
		end else begin
			gate_q <= gate_d;
		end
	end

	// Gate decode for the lanes
	always @* begin
		lane_pass = gate_passes(gate_d);
	end

	// The new gate state applies at once; a loading edge has the chosen clock low,
	// so a lane starts or stops only while low and no pulse is cut short
	always @* begin
		lane_on = 1'h0;
		if (lane_pass) begin
			lane_on = chosen_clk;
		end
	end

	// Every lane copies the same gated level
	genvar i;
	generate
		for (i = 0; i < `CFS_FANOUT_N; i = i + 1) begin : g_lane
			wire lane_lvl;
			assign lane_lvl = lane_on;
			assign lane_d[i] = lane_lvl;
			assign lane_n_d[i] = lane_inv(lane_lvl);
		end
	endgenerate

	// One register stage, equal for every lane
	always @(posedge clk_i) begin
		if (rst_i) begin
			fanout_out_o <= `CFS_OUT_RST;
		end else begin
			fanout_out_o <= lane_d;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			fanout_out_n_o <= `CFS_OUT_N_RST;
		end else begin
			fanout_out_n_o <= lane_n_d;
		end
	end

endmodule // cfs_clock_fanout
`default_nettype wire

/* verilog/cfs_map.vh */
// Constants for the clock fanout block with synchronous output gate
`ifndef CFS_MAP_VH
`define CFS_MAP_VH
`define CFS_FANOUT_N 5
`define CFS_SEL_DIFF 1'h0
`define CFS_SEL_AUX 1'h1
`define CFS_GATE_RST 2'h0
`define CFS_CLK_RST 1'h0
`define CFS_OUT_RST 5'h00
`define CFS_OUT_N_RST 5'h1f
`endif
